/* File: wdrc_watchdog_reset_control.v */
// Reset controller with watchdog timer, APB register slave
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "wdrc_regs.vh"

module wdrc_watchdog_reset_control
#(
   parameter [18:0] BUS_SHORT_COUNT = `WDRC_BUS_SHORT,
   parameter [18:0] BUS_LONG_COUNT  = `WDRC_BUS_LONG
)
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        clk_en,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        low_voltage_detect,
   input  wire        reset_pin_event,
   input  wire        illegal_opcode_event,
   input  wire        illegal_address_event,
   input  wire        clock_loss_event,
   input  wire        debug_reset_request,
   input  wire        background_debug_mode,
   input  wire        stop_mode,
   input  wire        slow_tick,
   output wire        system_reset,
   output reg         pc_load,
   output wire [15:0] reset_vector_hi_addr,
   output wire [15:0] reset_vector_lo_addr,
   output wire        interrupt_mask_set,
   output wire [15:0] stack_pointer_init,
   output wire        peripheral_disable,
   output wire        pin_output_disable,
   output wire        pin_pullup_disable,
   output wire        irq
);

   // ******************************************************
   // Reset sequencer
   // ******************************************************
   localparam [2:0] ST_HOLD = 3'b001;
   localparam [2:0] ST_LOAD = 3'b010;
   localparam [2:0] ST_RUN  = 3'b100;

   reg  [2:0]  state_r;
   reg  [2:0]  state_nxt;
   reg  [3:0]  hold_cnt_r;
   reg  [3:0]  hold_cnt_nxt;
   reg  [7:0]  cause_r;
   reg  [7:0]  cause_nxt;
   reg  [1:0]  opt1_r;
   reg         opt2_r;
   reg         opt1_lock_r;
   reg         opt2_lock_r;
   reg  [17:0] wd_cnt_r;
   reg         stop_d_r;
   reg  [2:0]  irq_stat_r;
   reg  [2:0]  irq_mask_r;
   wire        in_reset;
   wire        wd_overflow;
   wire        ext_request;
   wire        reset_request;

   assign in_reset = ~state_r[2];
   assign ext_request = low_voltage_detect | reset_pin_event |
                        illegal_opcode_event | illegal_address_event |
                        clock_loss_event | debug_reset_request;
   assign reset_request = ~in_reset & (ext_request | wd_overflow);

   always @*
   begin
      state_nxt = state_r;
      hold_cnt_nxt = hold_cnt_r;
      case (state_r)
         ST_HOLD:
         begin
            if (hold_cnt_r == `WDRC_RST_HOLD)
            begin
               state_nxt = ST_LOAD;
            end
            else
            begin
               hold_cnt_nxt = hold_cnt_r + 4'h1;
            end
         end
         ST_LOAD:
         begin
            state_nxt = ST_RUN;
         end
         ST_RUN:
         begin
            if (reset_request)
            begin
               state_nxt = ST_HOLD;
               hold_cnt_nxt = 4'h0;
            end
         end
         default:
         begin
            state_nxt = ST_HOLD;
            hold_cnt_nxt = 4'h0;
         end
      endcase
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= ST_HOLD;
         hold_cnt_r <= 4'h0;
         pc_load <= 1'b0;
      end
      else if (clk_en)
      begin
         state_r <= state_nxt;
         hold_cnt_r <= hold_cnt_nxt;
         pc_load <= state_nxt[1];
      end
   end

   // ******************************************************
   // Processor start state and pin control
   // ******************************************************
   assign system_reset = in_reset;
   assign reset_vector_hi_addr = `WDRC_VEC_HI_ADDR;
   assign reset_vector_lo_addr = `WDRC_VEC_LO_ADDR;
   assign interrupt_mask_set = in_reset;
   assign stack_pointer_init = `WDRC_STACK_INIT;
   assign peripheral_disable = in_reset;
   assign pin_output_disable = in_reset;
   assign pin_pullup_disable = in_reset;

   // ******************************************************
   // Reset cause register
   // ******************************************************
   always @*
   begin
      cause_nxt = cause_r;
      if (reset_request)
      begin
         cause_nxt = 8'h00;
         cause_nxt[`WDRC_CAUSE_PIN] = reset_pin_event;
         cause_nxt[`WDRC_CAUSE_WDOG] = wd_overflow;
         cause_nxt[`WDRC_CAUSE_ILOP] = illegal_opcode_event;
         cause_nxt[`WDRC_CAUSE_ILAD] = illegal_address_event;
         cause_nxt[`WDRC_CAUSE_CLK] = clock_loss_event;
         cause_nxt[`WDRC_CAUSE_LOWV] = low_voltage_detect;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cause_r <= `WDRC_RST_CAUSE;
      end
      else if (clk_en)
      begin
         cause_r <= cause_nxt;
      end
   end

   // ******************************************************
   // APB access decode
   // ******************************************************
   wire wr_en;
   wire rd_en;
   wire hit_cause;
   wire hit_opt1;
   wire hit_opt2;
   wire hit_stat;
   wire hit_mask;
   wire hit_count;
   wire mapped;
   wire service;
   wire opt1_first;
   wire opt2_first;
   reg  rd_vld_r;

   assign pready = clk_en & (pwrite | rd_vld_r);
   assign hit_cause = (paddr == `WDRC_OFF_CAUSE);
   assign hit_opt1 = (paddr == `WDRC_OFF_OPT1);
   assign hit_opt2 = (paddr == `WDRC_OFF_OPT2);
   assign hit_stat = (paddr == `WDRC_OFF_IRQ_STAT);
   assign hit_mask = (paddr == `WDRC_OFF_IRQ_MASK);
   assign hit_count = (paddr == `WDRC_OFF_COUNT);
   assign mapped = hit_cause | hit_opt1 | hit_opt2 | hit_stat | hit_mask |
                   hit_count;
   assign pslverr = psel & penable & ~mapped;
   assign wr_en = psel & penable & pwrite & clk_en & ~in_reset;
   assign rd_en = psel & ~pwrite & clk_en;
   assign service = wr_en & hit_cause;
   assign opt1_first = wr_en & hit_opt1 & ~opt1_lock_r;
   assign opt2_first = wr_en & hit_opt2 & ~opt2_lock_r;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
         rd_vld_r <= 1'b0;
      end
      else if (rd_en)
      begin
         rd_vld_r <= ~(penable & rd_vld_r);
         prdata <= 32'h00000000;
         if (hit_cause)
         begin
            prdata[7:0] <= cause_r;
         end
         if (hit_opt1)
         begin
            prdata[1:0] <= opt1_r;
         end
         if (hit_opt2)
         begin
            prdata[0] <= opt2_r;
         end
         if (hit_stat)
         begin
            prdata[2:0] <= irq_stat_r;
         end
         if (hit_mask)
         begin
            prdata[2:0] <= irq_mask_r;
         end
         if (hit_count)
         begin
            prdata[17:0] <= wd_cnt_r;
         end
      end
   end

   // ******************************************************
   // Write-once system options
   // ******************************************************
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         opt1_r <= `WDRC_RST_OPT1;
         opt2_r <= `WDRC_RST_OPT2;
         opt1_lock_r <= 1'b0;
         opt2_lock_r <= 1'b0;
      end
      else if (clk_en)
      begin
         if (in_reset)
         begin
            opt1_r <= `WDRC_RST_OPT1;
            opt2_r <= `WDRC_RST_OPT2;
            opt1_lock_r <= 1'b0;
            opt2_lock_r <= 1'b0;
         end
         else
         begin
            if (opt1_first)
            begin
               opt1_r <= pwdata[1:0];
               opt1_lock_r <= 1'b1;
            end
            if (opt2_first)
            begin
               opt2_r <= pwdata[0];
               opt2_lock_r <= 1'b1;
            end
         end
      end
   end

   // ******************************************************
   // Watchdog counter
   // ******************************************************
   wire        wd_enable;
   wire        wd_bus_clk;
   wire        wd_long;
   wire [18:0] wd_limit;
   wire [18:0] wd_last;
   wire        wd_step;
   wire        stop_entry;
   wire        wd_half;

   assign wd_enable = opt1_r[`WDRC_OPT1_EN];
   assign wd_long = opt1_r[`WDRC_OPT1_TSEL];
   assign wd_bus_clk = opt2_r;
   assign wd_limit = wd_bus_clk ?
                     (wd_long ? BUS_LONG_COUNT : BUS_SHORT_COUNT) :
                     (wd_long ? `WDRC_SLOW_LONG : `WDRC_SLOW_SHORT);
   assign wd_last = wd_limit - 19'h00001;
   assign wd_step = wd_enable & ~background_debug_mode & ~stop_mode &
                    (wd_bus_clk | slow_tick);
   assign stop_entry = stop_mode & ~stop_d_r;
   assign wd_overflow = wd_enable & ~in_reset & wd_step &
                        ({1'b0, wd_cnt_r} == wd_last);
   assign wd_half = wd_step & ({1'b0, wd_cnt_r} == {1'b0, wd_limit[18:1]});

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wd_cnt_r <= 18'h00000;
         stop_d_r <= 1'b0;
      end
      else if (clk_en)
      begin
         stop_d_r <= stop_mode;
         if (in_reset | service | opt1_first | opt2_first)
         begin
            wd_cnt_r <= 18'h00000;
         end
         else if (stop_entry & ~wd_bus_clk)
         begin
            wd_cnt_r <= 18'h00000;
         end
         else if (wd_step)
         begin
            wd_cnt_r <= wd_cnt_r + 18'h00001;
         end
      end
   end

   // ******************************************************
   // Interrupt status and mask
   // ******************************************************
   wire [2:0] irq_set;
   wire       lock_hit;

   assign lock_hit = wr_en & ((hit_opt1 & opt1_lock_r) |
                              (hit_opt2 & opt2_lock_r));
   assign irq_set = {wd_half & ~in_reset, lock_hit, service};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_irq
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               irq_stat_r[gi] <= 1'b0;
            end
            else if (clk_en)
            begin
               irq_stat_r[gi] <= irq_set[gi] |
                  (irq_stat_r[gi] & ~(wr_en & hit_stat & pwdata[gi]));
            end
         end
      end
   endgenerate

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_mask_r <= `WDRC_RST_IRQ;
      end
      else if (clk_en & wr_en & hit_mask)
      begin
         irq_mask_r <= pwdata[2:0];
      end
   end

   assign irq = |(irq_stat_r & irq_mask_r);

endmodule
`default_nettype wire

/* File: wdrc_regs.vh */
// Register map, field positions, reset values and counts of the reset controller
`ifndef WDRC_REGS_VH
`define WDRC_REGS_VH

// Register byte offsets
`define WDRC_OFF_CAUSE      8'h00
`define WDRC_OFF_OPT1       8'h04
`define WDRC_OFF_OPT2       8'h08
`define WDRC_OFF_IRQ_STAT   8'h0c
`define WDRC_OFF_IRQ_MASK   8'h10
`define WDRC_OFF_COUNT      8'h14

// Reset cause bit positions
`define WDRC_CAUSE_POR      7
`define WDRC_CAUSE_PIN      6
`define WDRC_CAUSE_WDOG     5
`define WDRC_CAUSE_ILOP     4
`define WDRC_CAUSE_ILAD     3
`define WDRC_CAUSE_CLK      2
`define WDRC_CAUSE_LOWV     1

// Option field positions
`define WDRC_OPT1_EN        0
`define WDRC_OPT1_TSEL      1
`define WDRC_OPT2_CSEL      0

// Reset values
`define WDRC_RST_CAUSE      8'h80
`define WDRC_RST_OPT1       2'h3
`define WDRC_RST_OPT2       1'h1
`define WDRC_RST_IRQ        3'h0

// Interrupt event positions
`define WDRC_IRQ_SERVICE    0
`define WDRC_IRQ_LOCKED     1
`define WDRC_IRQ_HALF       2

// Processor start state
`define WDRC_VEC_HI_ADDR    16'hfffe
`define WDRC_VEC_LO_ADDR    16'hffff
`define WDRC_STACK_INIT     16'h00ff

// Watchdog overflow counts
`define WDRC_SLOW_SHORT     19'h00020
`define WDRC_SLOW_LONG      19'h00100
`define WDRC_BUS_SHORT      19'h02000
`define WDRC_BUS_LONG       19'h40000

// Last hold count: the internal reset is held for this many cycles plus two
`define WDRC_RST_HOLD       4'hf

`endif

/* File: wdrc_checker.sv */
// Port assertions for the reset controller with watchdog
`timescale 1ns/10ps
`default_nettype none
module wdrc_checker
(
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       clk_en,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pwrite,
   input wire logic [7:0] paddr,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       reset_pin_event,
   input wire logic       system_reset,
   input wire logic       pc_load,
   input wire logic       interrupt_mask_set,
   input wire logic       peripheral_disable,
   input wire logic       pin_output_disable,
   input wire logic       pin_pullup_disable
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_load_before_run: assert property (
      $fell(system_reset) |-> $past(pc_load))
      else $error("start fetch missing before run");
   a_load_in_reset: assert property (pc_load |-> system_reset)
      else $error("start fetch outside reset");
   a_hold_length: assert property (
      $fell(system_reset) |-> $past(system_reset, 16))
      else $error("internal reset too short");
   a_mask_follows: assert property (interrupt_mask_set == system_reset)
      else $error("interrupt mask not tied to reset");
   a_pins_safe: assert property (system_reset |->
      peripheral_disable && pin_output_disable && pin_pullup_disable)
      else $error("pins or peripherals live in reset");
   a_pin_resets: assert property (!system_reset && clk_en && reset_pin_event
      |-> ##[1:2] system_reset)
      else $error("pin event gave no reset");
   a_unmapped_err: assert property (psel && penable && paddr > 8'h14
      |-> pslverr)
      else $error("unmapped access without error");
   a_mapped_ok: assert property (psel && penable && paddr <= 8'h14
      && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access with error");
   a_ready_enable: assert property (pready |-> clk_en)
      else $error("ready while clock enable low");
   a_write_ready: assert property (psel && penable && pwrite && clk_en
      |-> pready)
      else $error("write access not answered at once");
endmodule

bind wdrc_watchdog_reset_control wdrc_checker u_chk
(
   .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
   .pslverr(pslverr),
   .reset_pin_event(reset_pin_event), .system_reset(system_reset),
   .pc_load(pc_load), .interrupt_mask_set(interrupt_mask_set),
   .peripheral_disable(peripheral_disable),
   .pin_output_disable(pin_output_disable),
   .pin_pullup_disable(pin_pullup_disable)
);
`default_nettype wire

/* File: wdrc_cpu_model.sv */
// Processor side model: start state capture and slow tick source
`timescale 1ns/10ps
`default_nettype none
module wdrc_cpu_model
#(
   parameter int TICK_DIV = 4
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        pc_load,
   input  wire logic [15:0] vec_hi,
   input  wire logic [15:0] vec_lo,
   input  wire logic [15:0] stack_init,
   input  wire logic        imask,
   output var  logic        slow_tick,
   output var  logic        boot_ok,
   output var  logic [7:0]  boots
);
   int div;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div <= 0;
         slow_tick <= 1'b0;
         boots <= 8'h00;
         boot_ok <= 1'b1;
      end
      else
      begin
         div <= (div == TICK_DIV - 1) ? 0 : div + 1;
         slow_tick <= (div == TICK_DIV - 1);
         if (pc_load)
         begin
            boots <= boots + 8'h01;
            if (vec_hi !== 16'hfffe || vec_lo !== 16'hffff
                || stack_init !== 16'h00ff || imask !== 1'b1)
               boot_ok <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* File: test_watchdog_reset_control.sv */
// Self-checking bench for the reset controller with watchdog
`timescale 1ns/10ps
`default_nettype none
`define chk(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
   $display("Error %0t: got %h exp %h", $time, a, e); end end
module test_watchdog_reset_control;
   logic        pclk, presetn, clk_en, psel, penable, pwrite;
   logic        bdm, stp, cen_rand, slv;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rd, rnd, c1;
   logic [5:0]  ev;
   wire  [31:0] prdata;
   wire  [15:0] vh, vl, si;
   wire         pready, pslverr, tick, system_reset, pc_load, irq, im, ok;
   wire  [7:0]  boots;
   int          n_fail, compares, seed, cyc, nboot, i;

   wdrc_watchdog_reset_control #(.BUS_SHORT_COUNT(19'h00040),
      .BUS_LONG_COUNT(19'h00100)) u_dut
   (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .low_voltage_detect(ev[0]), .reset_pin_event(ev[1]),
      .illegal_opcode_event(ev[2]), .illegal_address_event(ev[3]),
      .clock_loss_event(ev[4]), .debug_reset_request(ev[5]),
      .background_debug_mode(bdm), .stop_mode(stp), .slow_tick(tick),
      .system_reset(system_reset), .pc_load(pc_load),
      .reset_vector_hi_addr(vh), .reset_vector_lo_addr(vl),
      .interrupt_mask_set(im), .stack_pointer_init(si),
      .peripheral_disable(), .pin_output_disable(),
      .pin_pullup_disable(), .irq(irq)
   );
   wdrc_cpu_model u_cpu
   (
      .pclk(pclk), .presetn(presetn), .pc_load(pc_load), .vec_hi(vh),
      .vec_lo(vl), .stack_init(si), .imask(im), .slow_tick(tick),
      .boot_ok(ok), .boots(boots)
   );

   function automatic logic [31:0] cause_of(input int k);
      logic [7:0] tab [6];
      begin
         tab = '{8'h02, 8'h40, 8'h10, 8'h08, 8'h04, 8'h00};
         return {24'h0, tab[k]};
      end
   endfunction

   task wrap_up;
      if (n_fail == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      slv = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask

   task rd_chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `chk(rd, e)
   endtask

   task wait_run;
      int k;
      k = 0;
      while (system_reset !== 1'b0 && k < 100)
      begin
         @(posedge pclk);
         #1 k++;
      end
      `chk(system_reset, 1'b0)
      nboot++;
   endtask

   task wait_rst(input int lo, input int hi);
      int k;
      k = 0;
      while (system_reset !== 1'b1 && k <= hi)
      begin
         @(posedge pclk);
         #1 k++;
      end
      `chk(k >= lo && k <= hi, 1'b1)
   endtask

   task evt(input int k);
      @(posedge pclk);
      ev <= 6'h01 << k;
      @(posedge pclk);
      ev <= 6'h00;
      wait_rst(1, 3);
      wait_run;
   endtask

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      rnd = $random(seed);
      clk_en <= !cen_rand | rnd[0];
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         wrap_up;
      end
   end

   initial
   begin
      presetn = 1'b0;
      {psel, penable, pwrite, bdm, stp, cen_rand} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      ev = 6'h00;
      {seed, n_fail, compares, nboot, cyc} = {32'd8, 128'd0};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      wait_run;
      rd_chk(8'h00, 32'h80);
      rd_chk(8'h04, 32'h3);
      rd_chk(8'h08, 32'h1);
      apb(1'b0, 8'h18, 32'h0);
      `chk(slv, 1'b1)
      apb(1'b1, 8'h00, $random(seed));
      rd_chk(8'h00, 32'h80);
      wait_rst(245, 260);
      wait_run;
      rd_chk(8'h00, 32'h20);
      rd_chk(8'h04, 32'h3);
      apb(1'b1, 8'h04, 32'h1);
      wait_rst(60, 68);
      wait_run;
      apb(1'b1, 8'h04, 32'h2);
      cen_rand = 1'b1;
      apb(1'b1, 8'h04, $random(seed));
      rd_chk(8'h04, 32'h2);
      apb(1'b0, 8'h0c, 32'h0);
      `chk(rd[1], 1'b1)
      `chk(irq, 1'b0)
      apb(1'b1, 8'h10, 32'h2);
      `chk(irq, 1'b1)
      apb(1'b1, 8'h0c, 32'h2);
      `chk(irq, 1'b0)
      cen_rand = 1'b0;
      repeat (300) @(posedge pclk);
      `chk(system_reset, 1'b0)
      for (i = 0; i < 6; i++)
      begin
         evt(i);
         rd_chk(8'h00, cause_of(i));
         rd_chk(8'h04, 32'h3);
      end
      for (i = 0; i < 2; i++)
      begin
         apb(1'b1, 8'h00, 32'h0);
         @(posedge pclk);
         {stp, bdm} <= i ? 2'b10 : 2'b01;
         apb(1'b0, 8'h14, 32'h0);
         c1 = rd;
         repeat (300) @(posedge pclk);
         rd_chk(8'h14, c1);
         `chk(system_reset, 1'b0)
         @(posedge pclk);
         {stp, bdm} <= 2'b00;
         apb(1'b0, 8'h14, 32'h0);
         `chk(rd > c1, 1'b1)
      end
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b1, 8'h04, 32'h1);
      repeat (40) @(posedge pclk);
      apb(1'b0, 8'h14, 32'h0);
      `chk(rd != 32'h0, 1'b1)
      @(posedge pclk);
      stp <= 1'b1;
      repeat (20) @(posedge pclk);
      rd_chk(8'h14, 32'h0);
      @(posedge pclk);
      stp <= 1'b0;
      wait_rst(120, 136);
      wait_run;
      `chk(ok, 1'b1)
      `chk(boots, nboot[7:0])
      wrap_up;
   end
endmodule
`default_nettype wire
